// *** design/abfp_port.sv ***
// asynchronous byte fifo port, device side
`timescale 1ns/1ps
module abfp_port
	import abfp_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// configuration
	input wire logic [2:0] port_mode,
	input wire logic remote_wake_en,
	input wire logic powered_indicator_n,
	// pins
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic send_now_wake_n,
	input wire logic [abfp_pkg::DATA_W-1:0] fifo_data_bus_in,
	output logic [abfp_pkg::DATA_W-1:0] fifo_data_bus_out,
	output logic fifo_data_bus_oe,
	output logic rx_data_available_n,
	output logic rx_data_available_oe,
	output logic tx_space_available_n,
	output logic tx_space_available_oe,
	// receive side, byte from usb
	input wire abfp_pkg::abfp_byte_t rx_in,
	output logic rx_in_ready,
	// transmit side, byte towards usb
	output abfp_pkg::abfp_byte_t tx_out,
	input wire logic tx_full,
	// usb engine requests
	output logic resume_req,
	output logic flush_req
);
	import abfp_pkg::*;

	logic [1:0] rd_sync_reg, wr_sync_reg, wk_sync_reg;
	logic rd_prev_reg, wr_prev_reg, wk_prev_reg;
	logic [DATA_W-1:0] d_sync1_reg, d_sync2_reg;
	logic mode_reg;
	abfp_rd_state_t rd_state_reg;
	abfp_byte_t hold_reg;
	logic rd_fall, rd_rise, wr_fall, wk_fall;
	logic hold_load;

	// edge decode shared by the strobe and wake detectors
	function automatic logic edge_fall(input logic prev_level, input logic cur_level);
		return prev_level && !cur_level;
	endfunction

	function automatic logic edge_rise(input logic prev_level, input logic cur_level);
		return !prev_level && cur_level;
	endfunction

	// two-flop synchronisers; pins are outside the clock domain
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rd_sync_reg <= STROBE_IDLE;
			wr_sync_reg <= STROBE_IDLE;
			wk_sync_reg <= STROBE_IDLE;
			d_sync1_reg <= DATA_RESET;
			d_sync2_reg <= DATA_RESET;
		end
		else
		begin
			rd_sync_reg <= {rd_sync_reg[0], read_strobe_n};
			wr_sync_reg <= {wr_sync_reg[0], write_strobe_n};
			wk_sync_reg <= {wk_sync_reg[0], send_now_wake_n};
			d_sync1_reg <= fifo_data_bus_in;
			d_sync2_reg <= d_sync1_reg;
		end
	end

	// edge detectors read only the second stage
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rd_prev_reg <= 1'b1;
			wr_prev_reg <= 1'b1;
			wk_prev_reg <= 1'b1;
		end
		else
		begin
			rd_prev_reg <= rd_sync_reg[1];
			wr_prev_reg <= wr_sync_reg[1];
			wk_prev_reg <= wk_sync_reg[1];
		end
	end

	assign rd_fall = mode_reg && edge_fall(rd_prev_reg, rd_sync_reg[1]);
	assign rd_rise = mode_reg && edge_rise(rd_prev_reg, rd_sync_reg[1]);
	assign wr_fall = mode_reg && edge_fall(wr_prev_reg, wr_sync_reg[1]);
	assign wk_fall = mode_reg && edge_fall(wk_prev_reg, wk_sync_reg[1]);
	// take a byte only between reads, so the byte under a low strobe never changes
	assign hold_load = mode_reg && !hold_reg.valid && rx_in.valid && rd_state_reg == ABFP_IDLE;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			mode_reg <= 1'b0;
		else
			mode_reg <= (port_mode == MODE_ASYNC_FIFO);
	end

	// one-byte holding stage feeding the pins
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			hold_reg <= '0;
		else if (rd_rise)
			hold_reg.valid <= 1'b0;
		else if (hold_load)
			hold_reg <= rx_in;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rx_in_ready <= 1'b0;
		else
			// acknowledge one cycle after the take; the source then moves on
			rx_in_ready <= hold_load;
	end

	// read sequence: drive while low, release on rise
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rd_state_reg <= ABFP_IDLE;
		else
			unique case (rd_state_reg)
				ABFP_IDLE: if (rd_fall) rd_state_reg <= ABFP_DRIVE;
				ABFP_DRIVE: if (rd_rise) rd_state_reg <= ABFP_RELEASE;
				ABFP_RELEASE: rd_state_reg <= ABFP_IDLE;
				default: rd_state_reg <= ABFP_IDLE;
			endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			fifo_data_bus_out <= DATA_RESET;
			fifo_data_bus_oe <= 1'b0;
		end
		else
		begin
			if (rd_fall)
				fifo_data_bus_out <= hold_reg.data;
			fifo_data_bus_oe <= mode_reg && !rd_sync_reg[1];
		end
	end

	// flags; output enables low in reset
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rx_data_available_n <= 1'b1;
			rx_data_available_oe <= 1'b0;
			tx_space_available_n <= 1'b1;
			tx_space_available_oe <= 1'b0;
		end
		else
		begin
			rx_data_available_oe <= 1'b1;
			tx_space_available_oe <= 1'b1;
			// flag drops only in idle with a byte held
			rx_data_available_n <= !(mode_reg && hold_reg.valid && !rd_rise
				&& rd_state_reg == ABFP_IDLE);
			tx_space_available_n <= !mode_reg || tx_full;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tx_out <= '0;
		else
		begin
			tx_out.valid <= wr_fall && !tx_full;
			if (wr_fall)
				tx_out.data <= d_sync2_reg;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			resume_req <= 1'b0;
			flush_req <= 1'b0;
		end
		else
		begin
			resume_req <= wk_fall && powered_indicator_n && remote_wake_en;
			flush_req <= wk_fall && !powered_indicator_n;
		end
	end

	// the bus checks and chk_write_capture tie outputs back to the pins, since pin to output is fixed at three clocks: two sync flops plus the output register
	chk_flag_release: assert property (@(posedge clock) disable iff (!rst_n)
		rd_rise
		|=> rx_data_available_n [*2])
		else $error("receive flag not raised after read");

	chk_flag_busy: assert property (@(posedge clock) disable iff (!rst_n)
		rd_state_reg != ABFP_IDLE
		|=> rx_data_available_n)
		else $error("receive flag low during a read");

	chk_flag_needs_byte: assert property (@(posedge clock) disable iff (!rst_n)
		!rx_data_available_n
		|-> $past(hold_reg.valid))
		else $error("receive flag low with no byte held");

	chk_bus_drive: assert property (@(posedge clock) disable iff (!rst_n)
		fifo_data_bus_oe
		|-> $past(!read_strobe_n, 3))
		else $error("data bus driven with read strobe high");

	chk_bus_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		$past(read_strobe_n, 3)
		|-> !fifo_data_bus_oe)
		else $error("data bus not released");

	chk_bus_release: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(read_strobe_n)
		|-> ##[1:4] !fifo_data_bus_oe)
		else $error("data bus held after read strobe rose");

	chk_read_data: assert property (@(posedge clock) disable iff (!rst_n)
		rd_fall
		|=> fifo_data_bus_out == $past(hold_reg.data))
		else $error("read byte wrong");

	chk_hold_take: assert property (@(posedge clock) disable iff (!rst_n)
		hold_load && !rd_rise
		|=> hold_reg.valid && rx_in_ready)
		else $error("receive byte not taken");

	chk_hold_advance: assert property (@(posedge clock) disable iff (!rst_n)
		rd_rise
		|=> !hold_reg.valid)
		else $error("receive stage not advanced");

	chk_tx_full_flag: assert property (@(posedge clock) disable iff (!rst_n)
		tx_full
		|=> tx_space_available_n)
		else $error("transmit flag low when full");

	chk_tx_space_free: assert property (@(posedge clock) disable iff (!rst_n)
		mode_reg && !tx_full
		|=> !tx_space_available_n)
		else $error("transmit flag high with space free");

	chk_write_capture: assert property (@(posedge clock) disable iff (!rst_n)
		wr_fall && !tx_full
		|=> tx_out.valid && tx_out.data == $past(fifo_data_bus_in, 3))
		else $error("write byte lost");

	chk_write_single: assert property (@(posedge clock) disable iff (!rst_n)
		!wr_fall
		|=> !tx_out.valid)
		else $error("transmit byte without write strobe");

	chk_resume_req: assert property (@(posedge clock) disable iff (!rst_n)
		resume_req
		|-> $past(powered_indicator_n && remote_wake_en))
		else $error("resume requested while awake or disabled");

	chk_wake_resume: assert property (@(posedge clock) disable iff (!rst_n)
		wk_fall && powered_indicator_n && remote_wake_en
		|=> resume_req)
		else $error("wake pulse gave no resume");

	chk_flush_req: assert property (@(posedge clock) disable iff (!rst_n)
		flush_req
		|-> $past(!powered_indicator_n))
		else $error("flush requested while suspended");

	chk_mode_gate: assert property (@(posedge clock) disable iff (!rst_n)
		!mode_reg
		|=> tx_space_available_n && rx_data_available_n)
		else $error("flags low outside fifo mode");

	chk_flag_oe: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n)
		|-> rx_data_available_oe && tx_space_available_oe)
		else $error("flags undriven after reset");

	// no disable here: this one must look inside reset
	chk_reset_float: assert property (@(posedge clock)
		!rst_n
		|=> !rx_data_available_oe && !tx_space_available_oe)
		else $error("flags driven during reset");

	cov_read: cover property (@(posedge clock) disable iff (!rst_n) rd_fall ##[1:20] rd_rise);
	cov_write: cover property (@(posedge clock) disable iff (!rst_n) tx_out.valid);
	cov_resume: cover property (@(posedge clock) disable iff (!rst_n) resume_req);
	cov_flush: cover property (@(posedge clock) disable iff (!rst_n) flush_req);
	cov_take: cover property (@(posedge clock) disable iff (!rst_n) rx_in_ready);
endmodule

// *** design/abfp_pkg.sv ***
// package for the asynchronous byte fifo port
package abfp_pkg;
	localparam int DATA_W = 8;
	localparam logic [2:0] MODE_ASYNC_FIFO = 3'h1;
	localparam logic [1:0] STROBE_IDLE = 2'h3;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// byte plus valid, used on both usb-side streams
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} abfp_byte_t;

	typedef enum logic [1:0] {
		ABFP_IDLE = 2'b00,
		ABFP_DRIVE = 2'b01,
		ABFP_RELEASE = 2'b11
	} abfp_rd_state_t;
endpackage

// *** bench/abfp_host_model.sv ***
// far-side controller model strobing the fifo port
`timescale 1ns/1ps
module abfp_host_model
	import abfp_pkg::*;
(
	// clock
	input wire logic clock,
	// port pins
	input wire logic [abfp_pkg::DATA_W-1:0] bus_dev,
	input wire logic bus_oe,
	input wire logic rxf_n,
	input wire logic txe_n,
	output logic rd_n = 1'b1,
	output logic wr_n = 1'b1,
	output logic [abfp_pkg::DATA_W-1:0] bus_in
);
	import abfp_pkg::*;
	logic [DATA_W-1:0] hd = 8'h5A;
	// released bus shows the inverse, never a stale byte
	assign bus_in = bus_oe ? bus_dev : hd;
	task automatic rd(output logic [DATA_W-1:0] d);
		repeat (40) if (rxf_n !== 1'b0) @(negedge clock);
		// no read while the flag stays high; the caller then gets an unknown byte
		d = 'x;
		if (rxf_n === 1'b0)
		begin
			rd_n = 1'b0;
			repeat (6) @(negedge clock);
			d = bus_in;
			rd_n = 1'b1;
			hd = ~d;
			repeat (8) @(negedge clock);
		end
	endtask
	// a full port is left alone, so no byte may come out of it
	task automatic wr(input logic [DATA_W-1:0] d);
		repeat (40) if (txe_n !== 1'b0) @(negedge clock);
		if (txe_n === 1'b0)
		begin
			hd = d;
			repeat (3) @(negedge clock);
			wr_n = 1'b0;
			repeat (6) @(negedge clock);
			wr_n = 1'b1;
			repeat (3) @(negedge clock);
			hd = ~d;
			repeat (4) @(negedge clock);
		end
	endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the fifo port
`timescale 1ns/1ps
module tb_top;
	import abfp_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] port_mode = 3'h1;
	logic wake_en = 1'b0;
	logic pwr_n = 1'b0;
	logic sw_n = 1'b1;
	logic tx_full = 1'b0;
	abfp_byte_t rx_in = '0;
	abfp_byte_t tx_out;
	logic rd_n, wr_n, bus_oe, rx_n, rx_oe, tx_n, tx_oe, rdy, resume_req, flush_req;
	logic [DATA_W-1:0] bus_in, bus_out, d, e, got;
	logic [DATA_W-1:0] exp_q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int n_resume = 0;
	int n_flush = 0;
	int n_ready = 0;
	// pull-ups hold the flags high while undriven
	wire rx_w = rx_oe ? rx_n : 1'b1;
	wire tx_w = tx_oe ? tx_n : 1'b1;
	initial forever #12.5 clock = ~clock;
	abfp_port u_abfp_port (.clock(clock), .rst_n(rst_n), .port_mode(port_mode),
		.remote_wake_en(wake_en), .powered_indicator_n(pwr_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .send_now_wake_n(sw_n), .fifo_data_bus_in(bus_in),
		.fifo_data_bus_out(bus_out), .fifo_data_bus_oe(bus_oe), .rx_data_available_n(rx_n),
		.rx_data_available_oe(rx_oe), .tx_space_available_n(tx_n),
		.tx_space_available_oe(tx_oe), .rx_in(rx_in), .rx_in_ready(rdy), .tx_out(tx_out),
		.tx_full(tx_full), .resume_req(resume_req), .flush_req(flush_req));
	abfp_host_model u_abfp_host_model (.clock(clock), .bus_dev(bus_out), .bus_oe(bus_oe),
		.rxf_n(rx_w), .txe_n(tx_w), .rd_n(rd_n), .wr_n(wr_n), .bus_in(bus_in));
	task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] x);
		n_tests++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("Error at %0t: got %0h expected %0h", $time, g, x);
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		if (tx_out.valid === 1'b1)
		begin
			// a byte with no note is a refused write that got through
			if (exp_q.size() == 0)
				chk(tx_out.data, ~tx_out.data);
			else
				chk(tx_out.data, exp_q.pop_front());
		end
		n_resume += int'(resume_req === 1'b1);
		n_flush += int'(flush_req === 1'b1);
		n_ready += int'(rdy === 1'b1);
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end
	initial
	begin
		void'($urandom(35));
		repeat (5) @(negedge clock);
		chk(8'({rx_oe, tx_oe}), 8'h00);
		rst_n = 1'b1;
		d = 8'($urandom);
		e = 8'($urandom);
		rx_in = {1'b1, d};
		repeat (10) @(negedge clock);
		rx_in = {1'b1, e};
		u_abfp_host_model.rd(got);
		chk(got, d);
		chk(8'(bus_oe), 8'h00);
		repeat (10) @(negedge clock);
		rx_in.valid = 1'b0;
		chk(8'(rx_w), 8'h00);
		u_abfp_host_model.rd(got);
		chk(got, e);
		chk(8'(rx_w), 8'h01);
		chk(8'(n_ready), 8'h02);
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($urandom);
			exp_q.push_back(d);
			u_abfp_host_model.wr(d);
		end
		tx_full = 1'b1;
		repeat (6) @(negedge clock);
		chk(8'(tx_w), 8'h01);
		u_abfp_host_model.wr(8'hA5);
		tx_full = 1'b0;
		repeat (6) @(negedge clock);
		chk(8'(tx_w), 8'h00);
		wake_en = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			pwr_n = ~i[0];
			sw_n = 1'b0;
			repeat (6) @(negedge clock);
			sw_n = 1'b1;
			repeat (8) @(negedge clock);
		end
		chk(8'(n_resume), 8'h01);
		chk(8'(n_flush), 8'h01);
		port_mode = 3'h2;
		repeat (8) @(negedge clock);
		chk(8'({rx_w, tx_w}), 8'h03);
		complete_run();
	end
endmodule
